//--- design/lcd_params.svh
// constants of the character lcd instruction decoder: offsets, field positions, reset values, timing
`ifndef LCD_PARAMS_SVH
`define LCD_PARAMS_SVH
// apb register byte offsets
`define LCD_OFF_INSTR     8'h00
`define LCD_OFF_DATA      8'h04
`define LCD_OFF_MODE      8'h08
`define LCD_OFF_SHIFT     8'h0c
// mode register field positions
`define LCD_MODE_DISP     0
`define LCD_MODE_CURSOR   1
`define LCD_MODE_BLINK    2
`define LCD_MODE_INC      3
`define LCD_MODE_SHIFT    4
`define LCD_MODE_BUS8     5
`define LCD_MODE_TWOLINE  6
`define LCD_MODE_DHEIGHT  7
`define LCD_MODE_EXTTAB   8
`define LCD_MODE_FONT16   9
`define LCD_MODE_BIAS     10
`define LCD_MODE_OSC_LO   11
`define LCD_MODE_SEL_LO   14
`define LCD_MODE_BUSY     16
// option pin positions in the synchronised pin vector
`define LCD_PIN_W         4
`define LCD_PIN_EXT       0
`define LCD_PIN_CLS       1
`define LCD_PIN_OPFA      2
`define LCD_PIN_OPFB      3
// address map of the display ram and reset values
`define LCD_AC_RESET      7'h00
`define LCD_SPACE_CODE    8'h20
`define LCD_BLINK_PATTERN 8'hff
`define LCD_LINE1_END     7'h27
`define LCD_LINE2_START   7'h40
`define LCD_LINE2_END     7'h67
`define LCD_ONELINE_END   7'h4f
`define LCD_GLYPH_MASK    7'h3f
`define LCD_SYMBOL_MASK   7'h0f
// timing
`define LCD_CLK_PERIOD_NS 10
`define LCD_EXEC_TIME_NS  26300
`define LCD_CLEAR_TIME_NS 1080000
`define LCD_EXEC_CYCLES   ((`LCD_EXEC_TIME_NS + `LCD_CLK_PERIOD_NS - 1) / `LCD_CLK_PERIOD_NS)
`define LCD_CLEAR_CYCLES  ((`LCD_CLEAR_TIME_NS + `LCD_CLK_PERIOD_NS - 1) / `LCD_CLK_PERIOD_NS)
`define LCD_BLINK_CYCLES  2048
`define LCD_CNT_W         17
`endif

//--- design/lcd_pkg.sv
// types shared by the character lcd instruction decoder modules
`include "lcd_params.svh"
package lcd_pkg;
    typedef enum logic [1:0] {LCD_RAM_DISPLAY, LCD_RAM_GLYPH, LCD_RAM_SYMBOL} lcd_ram_type;
    typedef enum logic [1:0] {LCD_IDLE, LCD_EXEC, LCD_CLEAR} lcd_fsm_type;

    typedef struct packed {
        logic [`LCD_PIN_W-1:0] s1;
        logic [`LCD_PIN_W-1:0] s2;
    } lcd_sync_type;

    typedef struct packed {
        logic       hi_pend;
        logic [3:0] hi_nib;
    } lcd_nib_type;

    typedef struct packed {
        logic                   ready;
        logic [31:0]            prdata;
        logic                   pslverr;
        lcd_fsm_type            state;
        logic                   busy;
        logic [`LCD_CNT_W-1:0]  cnt;
        logic [6:0]             clr_idx;
        logic [6:0]             ac;
        lcd_ram_type            sel;
        logic                   inc;
        logic                   shift_en;
        logic                   disp_on;
        logic                   cur_on;
        logic                   blink_on;
        logic                   bus8;
        logic                   two_line;
        logic                   dh;
        logic                   ext_tab;
        logic                   bias;
        logic [2:0]             osc;
        logic [6:0]             disp_shift;
        logic [127:0][7:0]      dram;
        logic [63:0][7:0]       gram;
        logic [15:0][7:0]       sram;
        logic [7:0]             rbuf;
        logic [15:0]            blink_cnt;
        logic                   blink_ph;
        logic [7:0]             cursor_char;
        logic                   font16;
        logic                   bias_valid;
        logic                   osc_valid;
    } lcd_core_type;
endpackage

//--- design/lcd_sync.sv
// two flip-flop synchroniser for the static option pins
`timescale 1ns/10ps
`include "lcd_params.svh"
module lcd_sync import lcd_pkg::*; (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // pins in, synchronised levels out
    input  wire logic [`LCD_PIN_W-1:0] pin_in,
    output logic      [`LCD_PIN_W-1:0] pin_sync
);
    lcd_sync_type r;
    lcd_sync_type n;

    // first stage feeds only the second stage
    always_comb begin
        n    = r;
        n.s1 = pin_in;
        n.s2 = r.s1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign pin_sync = r.s2;
endmodule

//--- design/lcd_nibble.sv
// joins two 4-bit host transfers into one byte when the narrow bus is selected
`timescale 1ns/10ps
module lcd_nibble import lcd_pkg::*; (
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // mode and incoming transfer
    input  wire logic       bus_8bit,
    input  wire logic       xfer_stb,
    input  wire logic [7:0] xfer_in,
    // assembled byte
    output logic            high_next,
    output logic            byte_stb,
    output logic [7:0]      byte_out
);
    lcd_nib_type r;
    lcd_nib_type n;

    // the high nibble comes first; the wide bus keeps the toggle parked
    always_comb begin
        n = r;
        if (bus_8bit) begin
            n.hi_pend = 1'b0;
        end else if (xfer_stb) begin
            n.hi_pend = ~r.hi_pend;
            n.hi_nib  = xfer_in[3:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign high_next = ~r.hi_pend;
    assign byte_stb  = xfer_stb & (bus_8bit | r.hi_pend); // see [R11]
    assign byte_out  = bus_8bit ? xfer_in : {r.hi_nib, xfer_in[3:0]};
endmodule

//--- design/lcd_decoder.sv
// instruction decoder, address counter and internal rams of a character lcd controller on apb
//
// Functional notes
// [R01] clear fills display ram with space, address zero, cursor home, increment mode
// [R02] home zeroes address counter and display shift, ram untouched
// [R03] increment bit high steps address up, low steps it down
// [R04] glyph ram accesses step in the same entry direction
// [R05] only display ram writes shift the display, when shift bit set
// [R06] display-on bit blanks output without touching stored data
// [R07] cursor-on bit hides cursor, entry direction kept
// [R08] blink alternates cursor cell between all ones and stored character
// [R09] cursor shift moves address counter; screen shift leaves it alone
// [R10] two-line cursor wraps from first line end to second line; shift hits all
// [R11] bus width bit picks 8-bit or two 4-bit transfers per byte
// [R12] tall font in one-line mode limits display addresses to 27h
// [R13] line bit selects two or one lines; normal font 5x8
// [R14] table-select bit picks extension or normal decoding of later commands
// [R15] glyph address command loads 6 bits and routes data to glyph ram
// [R16] one-line addresses 00h-4fh; two-line 00h-27h and 40h-67h
// [R17] status read gives busy in bit 7, address below; busy blocks commands
// [R18] every ram data access steps the address counter by one
// [R19] data write lands in the ram chosen by the last address set
// [R20] host sets an address before reading; first read otherwise stale
// [R21] bias bit picks 1/4 or 1/5 unless both follower options high
// [R22] oscillator trim code acts only with clock source pin high
// [R23] symbol address 00h-0fh, only with extension table selected
// [R24] extension option pin high forces the 5x8 font
// [R25] busy from command acceptance to completion; clear and home long
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
`include "lcd_params.svh"
module lcd_decoder import lcd_pkg::*; #(
    parameter int unsigned EXEC_CYCLES  = `LCD_EXEC_CYCLES,
    parameter int unsigned CLEAR_CYCLES = `LCD_CLEAR_CYCLES,
    parameter int unsigned BLINK_CYCLES = `LCD_BLINK_CYCLES
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // option pins, asynchronous static straps
    input  wire logic        extension_option_pin,
    input  wire logic        clock_source_pin,
    input  wire logic        follower_option_a,
    input  wire logic        follower_option_b,
    // display drive state
    output logic             busy_flag,
    output logic             display_on,
    output logic             cursor_on,
    output logic [6:0]       cursor_addr,
    output logic [7:0]       cursor_char,
    output logic [6:0]       display_shift,
    output logic             two_line,
    output logic             font_tall,
    output logic             bias_quarter,
    output logic             bias_valid,
    output logic [2:0]       osc_trim,
    output logic             osc_trim_valid
);
    localparam int unsigned CW = `LCD_CNT_W;
    localparam logic [CW-1:0] EXEC_LOAD  = CW'(EXEC_CYCLES - 1);
    localparam logic [CW-1:0] CLEAR_LOAD = CW'(CLEAR_CYCLES - 1);
    localparam logic [15:0]   BLINK_LAST = 16'(BLINK_CYCLES - 1);

    lcd_core_type          r;
    lcd_core_type          n;
    logic [`LCD_PIN_W-1:0] pins;
    logic                  acc;
    logic                  hit_instr;
    logic                  hit_data;
    logic                  xfer_stb;
    logic                  high_next;
    logic                  byte_stb;
    logic [7:0]            byte_val;
    logic [7:0]            b;
    logic [6:0]            next_ac;
    logic [6:0]            span;

    // last display address of the first line in the active line layout, also the shift wrap point
    function automatic logic [6:0] lcd_span(input logic two, input logic f16);
        lcd_span = (two | f16) ? `LCD_LINE1_END : `LCD_ONELINE_END; // see [R12] see [R16]
    endfunction

    // one step of the address counter inside the selected ram's range
    function automatic logic [6:0] lcd_step(input logic [6:0] a, input lcd_ram_type s, input logic up,
                                            input logic two, input logic f16);
        logic [6:0] lim;
        lim = lcd_span(two, f16);
        unique case (s)
            LCD_RAM_GLYPH:  lcd_step = (up ? a + 7'h01 : a - 7'h01) & `LCD_GLYPH_MASK;  // see [R04]
            LCD_RAM_SYMBOL: lcd_step = (up ? a + 7'h01 : a - 7'h01) & `LCD_SYMBOL_MASK;
            default: begin
                if (two) begin // see [R10]
                    if (up) begin
                        lcd_step = (a == `LCD_LINE1_END) ? `LCD_LINE2_START :
                                   (a >= `LCD_LINE2_END) ? `LCD_AC_RESET : a + 7'h01;
                    end else begin
                        lcd_step = (a == `LCD_LINE2_START) ? `LCD_LINE1_END :
                                   (a == `LCD_AC_RESET) ? `LCD_LINE2_END : a - 7'h01;
                    end
                end else if (up) begin // see [R03]
                    lcd_step = (a >= lim) ? `LCD_AC_RESET : a + 7'h01;
                end else begin
                    lcd_step = (a == `LCD_AC_RESET) ? lim : a - 7'h01;
                end
            end
        endcase
    endfunction

    // display shift offset rotated by one position
    function automatic logic [6:0] lcd_rot(input logic [6:0] off, input logic left, input logic [6:0] lim);
        if (left) begin
            lcd_rot = (off >= lim) ? 7'h00 : off + 7'h01;
        end else begin
            lcd_rot = (off == 7'h00) ? lim : off - 7'h01;
        end
    endfunction

    // byte of the selected ram at an address
    function automatic logic [7:0] lcd_fetch(input lcd_core_type st, input lcd_ram_type s, input logic [6:0] a);
        unique case (s)
            LCD_RAM_GLYPH:  lcd_fetch = st.gram[a[5:0]];
            LCD_RAM_SYMBOL: lcd_fetch = st.sram[a[3:0]];
            default:        lcd_fetch = st.dram[a];
        endcase
    endfunction

    // byte or nibble presented on a read, high nibble first on the narrow bus
    function automatic logic [31:0] lcd_half(input logic [7:0] v, input logic wide, input logic hi);
        lcd_half = wide ? {24'h0, v} : (hi ? {28'h0, v[7:4]} : {28'h0, v[3:0]});
    endfunction

    lcd_sync u_sync (
        .pclk     (pclk),
        .presetn  (presetn),
        .pin_in   ({follower_option_b, follower_option_a, clock_source_pin, extension_option_pin}),
        .pin_sync (pins)
    );

    // bus decode; data port and command writes are refused while busy, status reads never
    assign acc       = psel & penable & r.ready;
    assign hit_instr = (paddr == `LCD_OFF_INSTR);
    assign hit_data  = (paddr == `LCD_OFF_DATA);
    assign xfer_stb  = acc & ((hit_data & ~r.busy) | (hit_instr & (~pwrite | ~r.busy))); // see [R17]
    assign b         = byte_val;
    assign span      = lcd_span(r.two_line, r.font16);

    lcd_nibble u_nibble (
        .pclk      (pclk),
        .presetn   (presetn),
        .bus_8bit  (r.bus8),
        .xfer_stb  (xfer_stb),
        .xfer_in   (pwdata[7:0]),
        .high_next (high_next),
        .byte_stb  (byte_stb),
        .byte_out  (byte_val)
    );

    always_comb begin
        n       = r;
        next_ac = lcd_step(r.ac, r.sel, r.inc, r.two_line, r.font16);

        // apb: one wait state, read data captured in the first access cycle
        n.ready   = psel & penable & ~r.ready;
        n.prdata  = 32'h0;
        n.pslverr = 1'b0;
        if (n.ready && !pwrite) begin
            unique case (paddr)
                `LCD_OFF_INSTR: n.prdata = lcd_half({r.busy, r.ac}, r.bus8, high_next); // see [R17]
                `LCD_OFF_DATA:  n.prdata = lcd_half(r.rbuf, r.bus8, high_next);
                `LCD_OFF_MODE: begin
                    n.prdata[`LCD_MODE_DISP]    = r.disp_on;
                    n.prdata[`LCD_MODE_CURSOR]  = r.cur_on;
                    n.prdata[`LCD_MODE_BLINK]   = r.blink_on;
                    n.prdata[`LCD_MODE_INC]     = r.inc;
                    n.prdata[`LCD_MODE_SHIFT]   = r.shift_en;
                    n.prdata[`LCD_MODE_BUS8]    = r.bus8;
                    n.prdata[`LCD_MODE_TWOLINE] = r.two_line;
                    n.prdata[`LCD_MODE_DHEIGHT] = r.dh;
                    n.prdata[`LCD_MODE_EXTTAB]  = r.ext_tab;
                    n.prdata[`LCD_MODE_FONT16]  = r.font16;
                    n.prdata[`LCD_MODE_BIAS]    = r.bias;
                    n.prdata[`LCD_MODE_OSC_LO +: 3] = r.osc;
                    n.prdata[`LCD_MODE_SEL_LO +: 2] = r.sel;
                    n.prdata[`LCD_MODE_BUSY]    = r.busy;
                end
                `LCD_OFF_SHIFT: n.prdata = {25'h0, r.disp_shift};
                default:        n.pslverr = 1'b1;
            endcase
        end else if (n.ready) begin
            n.pslverr = ~(hit_instr | hit_data); // mode and shift words are read-only
        end

        // execution timer; the clear state wipes one display cell per cycle
        unique case (r.state)
            LCD_IDLE: begin
            end
            LCD_EXEC: begin
                if (r.cnt == '0) begin
                    n.state = LCD_IDLE;
                end else begin
                    n.cnt = r.cnt - CW'(1);
                end
            end
            LCD_CLEAR: begin
                n.dram[r.clr_idx] = `LCD_SPACE_CODE; // see [R01]
                n.clr_idx         = r.clr_idx + 7'h01;
                if (r.cnt == '0) begin
                    n.state = LCD_IDLE;
                end else begin
                    n.cnt = r.cnt - CW'(1);
                end
            end
        endcase

        // assembled command byte
        if (byte_stb && pwrite && hit_instr) begin
            n.state = LCD_EXEC; // see [R25]
            n.cnt   = EXEC_LOAD;
            if (b[7]) begin
                n.ac   = b[6:0];
                n.sel  = LCD_RAM_DISPLAY;
                n.rbuf = lcd_fetch(r, LCD_RAM_DISPLAY, b[6:0]);
            end else if (b[6]) begin
                if (!r.ext_tab) begin // see [R14]
                    n.ac   = {1'b0, b[5:0]}; // see [R15]
                    n.sel  = LCD_RAM_GLYPH;
                    n.rbuf = lcd_fetch(r, LCD_RAM_GLYPH, {1'b0, b[5:0]});
                end else if (b[5:4] == 2'b00) begin
                    n.ac   = {3'b000, b[3:0]}; // see [R23]
                    n.sel  = LCD_RAM_SYMBOL;
                    n.rbuf = lcd_fetch(r, LCD_RAM_SYMBOL, {3'b000, b[3:0]});
                end
            end else if (b[5]) begin
                n.bus8     = b[4]; // see [R11]
                n.two_line = b[3]; // see [R13]
                n.dh       = b[2];
                n.ext_tab  = b[0]; // see [R14]
            end else if (b[4]) begin
                if (r.ext_tab) begin
                    n.bias = b[3];
                    n.osc  = b[2:0];
                end else if (!b[3]) begin
                    n.ac = lcd_step(r.ac, r.sel, b[2], r.two_line, r.font16); // see [R09]
                end else begin
                    n.disp_shift = lcd_rot(r.disp_shift, ~b[2], span); // see [R09] see [R10]
                end
            end else if (b[3]) begin
                n.disp_on  = b[2]; // see [R06]
                n.cur_on   = b[1]; // see [R07]
                n.blink_on = b[0];
            end else if (b[2]) begin
                n.inc      = b[1];
                n.shift_en = b[0];
            end else if (b[1]) begin
                n.ac         = `LCD_AC_RESET; // see [R02]
                n.sel        = LCD_RAM_DISPLAY;
                n.disp_shift = 7'h00;
                n.cnt        = CLEAR_LOAD;
            end else if (b[0]) begin
                n.state      = LCD_CLEAR; // see [R01]
                n.cnt        = CLEAR_LOAD;
                n.clr_idx    = 7'h00;
                n.ac         = `LCD_AC_RESET;
                n.sel        = LCD_RAM_DISPLAY;
                n.inc        = 1'b1;
                n.disp_shift = 7'h00;
            end
        end

        // ram data write: selected ram, then step and optional display shift
        if (byte_stb && pwrite && hit_data) begin
            unique case (r.sel) // see [R19]
                LCD_RAM_GLYPH:  n.gram[r.ac[5:0]] = b;
                LCD_RAM_SYMBOL: n.sram[r.ac[3:0]] = b;
                default:        n.dram[r.ac]      = b;
            endcase
            n.ac    = next_ac; // see [R18]
            n.state = LCD_EXEC;
            n.cnt   = EXEC_LOAD;
            if (r.shift_en && r.sel == LCD_RAM_DISPLAY) begin
                n.disp_shift = lcd_rot(r.disp_shift, r.inc, span); // see [R05]
            end
        end

        // ram data read: hand out the prefetched byte, then fetch the next one
        if (byte_stb && !pwrite && hit_data) begin
            n.ac    = next_ac; // see [R18]
            n.rbuf  = lcd_fetch(r, r.sel, next_ac); // see [R20]
            n.state = LCD_EXEC;
            n.cnt   = EXEC_LOAD;
        end
        n.busy = (n.state != LCD_IDLE); // see [R25]

        // blink timer and cursor cell
        if (r.blink_cnt >= BLINK_LAST) begin
            n.blink_cnt = 16'h0;
            n.blink_ph  = ~r.blink_ph;
        end else begin
            n.blink_cnt = r.blink_cnt + 16'h1;
        end
        n.cursor_char = (r.blink_on && r.blink_ph) ? `LCD_BLINK_PATTERN : r.dram[r.ac]; // see [R08]

        // option pin qualified settings
        n.font16     = n.dh & ~n.two_line & ~pins[`LCD_PIN_EXT]; // see [R12] see [R24]
        n.bias_valid = ~(pins[`LCD_PIN_OPFA] & pins[`LCD_PIN_OPFB]); // see [R21]
        n.osc_valid  = pins[`LCD_PIN_CLS]; // see [R22]
    end

    // reset state: 8-bit bus, one line, display off, increment entry
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r       <= '0;
            r.state <= LCD_IDLE;
            r.sel   <= LCD_RAM_DISPLAY;
            r.inc   <= 1'b1;
            r.bus8  <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // outputs straight from state flops
    assign prdata         = r.prdata;
    assign pready         = r.ready;
    assign pslverr        = r.pslverr;
    assign busy_flag      = r.busy;
    assign display_on     = r.disp_on;
    assign cursor_on      = r.cur_on;
    assign cursor_addr    = r.ac;
    assign cursor_char    = r.cursor_char;
    assign display_shift  = r.disp_shift;
    assign two_line       = r.two_line;
    assign font_tall      = r.font16;
    assign bias_quarter   = r.bias;
    assign bias_valid     = r.bias_valid;
    assign osc_trim       = r.osc;
    assign osc_trim_valid = r.osc_valid;
endmodule

//--- verification/lcd_decoder_properties.sv
// port-level assertions of the lcd instruction decoder
`timescale 1ns/10ps
module lcd_decoder_properties (
    // clock, reset and bus handshake
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    // option straps
    input wire logic follower_option_a,
    input wire logic follower_option_b,
    input wire logic clock_source_pin,
    input wire logic extension_option_pin,
    // display state
    input wire logic busy_flag,
    input wire logic display_on,
    input wire logic two_line,
    input wire logic font_tall,
    input wire logic bias_valid,
    input wire logic osc_trim_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // bus answers come after exactly one wait state and last one cycle
    a_ready_one: assert property (pready |=> !pready) else $error("pready held too long");
    a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("pready late");
    // busy rises only after a completed transfer (data reads execute too); display state only after a write
    a_busy_cause: assert property ($rose(busy_flag) |-> $past(psel && penable && pready))
        else $error("busy rose without a transfer");
    a_disp_cause: assert property ($changed(display_on) |-> $past(psel && penable && pready && pwrite))
        else $error("display state moved without a write");
    a_font_rule: assert property (font_tall |-> !two_line) else $error("tall font in two lines");
    // straps pass two sync flops and a register, so five steady samples are enough
    a_bias_valid: assert property ((follower_option_a && follower_option_b) [*5] |-> !bias_valid)
        else $error("bias valid with external resistors");
    a_osc_valid: assert property (clock_source_pin [*5] |-> osc_trim_valid)
        else $error("oscillator trim not valid");
    a_ext_font: assert property (extension_option_pin [*5] |-> !font_tall)
        else $error("tall font with extension strap");
endmodule

bind lcd_decoder lcd_decoder_properties i_props (.pclk, .presetn, .psel, .penable, .pwrite, .pready,
    .follower_option_a, .follower_option_b, .clock_source_pin, .extension_option_pin, .busy_flag,
    .display_on, .two_line, .font_tall, .bias_valid, .osc_trim_valid);

//--- verification/lcd_host.sv
// host processor model that drives the decoder over apb
`timescale 1ns/10ps
module lcd_host (
    // clock and answers from the decoder
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        busy_flag,
    // apb request
    output logic      [7:0]  paddr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0; // bus parked idle before the first transfer
    // one transfer, request held until pready is sampled high at an edge
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= {24'h000000, data};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    // a command sent while busy would be lost, so wait the flag out
    task automatic idle;
        repeat (2) @(posedge pclk);
        while (busy_flag !== 1'b0) @(posedge pclk);
    endtask
endmodule

//--- verification/lcd_decoder_tb.sv
// self-checking testbench of the lcd instruction decoder
`timescale 1ns/10ps
module lcd_decoder_tb;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, busy_flag, display_on, cursor_on;
    logic two_line, font_tall, bias_quarter, bias_valid, osc_trim_valid;
    logic extension_option_pin, clock_source_pin, follower_option_a, follower_option_b;
    logic [7:0]  paddr, cursor_char, data_byte, expect_q[$];
    logic [31:0] pwdata, prdata;
    logic [6:0]  cursor_addr, display_shift;
    logic [2:0]  osc_trim;
    int          miscompares, compares, cycles;

    lcd_decoder #(.EXEC_CYCLES(10), .CLEAR_CYCLES(130), .BLINK_CYCLES(8)) i_dut (.pclk, .presetn, .paddr,
        .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .extension_option_pin, .clock_source_pin,
        .follower_option_a, .follower_option_b, .busy_flag, .display_on, .cursor_on, .cursor_addr, .cursor_char,
        .display_shift, .two_line, .font_tall, .bias_quarter, .bias_valid, .osc_trim, .osc_trim_valid);
    lcd_host i_host (.pclk, .pready, .busy_flag, .paddr, .psel, .penable, .pwrite, .pwdata);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        i_host.xfer(1'b1, addr, data);
        i_host.idle();
    endtask
    // the note is queued before the read starts, the monitor pops it
    task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
        expect_q.push_back(exp);
        i_host.xfer(1'b0, addr, 8'h00);
        i_host.idle();
    endtask
    task automatic complete_run;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // read monitor: each completed read is matched against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && expect_q.size() > 0)
            check(prdata[7:0], expect_q.pop_front());
    end
    // hang guard, well above the roughly seven hundred cycles the sequence needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 8000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        {miscompares, compares, cycles, presetn} = '0;
        {extension_option_pin, clock_source_pin, follower_option_a, follower_option_b} = 4'h6;
        void'($urandom(13));
        data_byte = 8'($urandom());
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        wr(8'h00, 8'h01);
        wr(8'h04, data_byte);
        rd(8'h00, 8'h01);
        wr(8'h00, 8'h80);
        rd(8'h04, data_byte);
        rd(8'h04, 8'h20);
        wr(8'h00, 8'h10);
        rd(8'h00, 8'h01);
        wr(8'h00, 8'h14);
        wr(8'h00, 8'h18);
        rd(8'h00, 8'h02);
        rd(8'h0c, 8'h01);
        wr(8'h00, 8'h02);
        rd(8'h0c, 8'h00);
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h04);
        wr(8'h04, data_byte);
        rd(8'h00, 8'h4f);
        wr(8'h00, 8'h07);
        wr(8'h04, data_byte);
        rd(8'h0c, 8'h01);
        rd(8'h00, 8'h00);
        wr(8'h00, 8'h38);
        check({7'h00, two_line}, 8'h01);
        wr(8'h00, 8'ha7);
        wr(8'h04, data_byte);
        rd(8'h00, 8'h40);
        wr(8'h00, 8'h7f);
        wr(8'h04, data_byte);
        rd(8'h00, 8'h00);
        // second command lands while busy and must be dropped
        i_host.xfer(1'b1, 8'h00, 8'h85);
        wr(8'h00, 8'h90);
        rd(8'h00, 8'h05);
        wr(8'h00, 8'h0f);
        check({6'h00, display_on, cursor_on}, 8'h03);
        wr(8'h00, 8'h39);
        wr(8'h00, 8'h1d);
        check({2'h0, osc_trim_valid, bias_valid, bias_quarter, osc_trim}, 8'h3d);
        wr(8'h00, 8'h24);
        wr(8'h00, 8'h0a);
        wr(8'h00, 8'h07);
        rd(8'h04, data_byte >> 4);
        rd(8'h04, data_byte & 8'h0f);
        check({font_tall, cursor_addr}, 8'h80);
        extension_option_pin <= 1'b1;
        follower_option_b <= 1'b1;
        repeat (6) @(posedge pclk);
        check({6'h00, bias_valid, font_tall}, 8'h00);
        complete_run();
    end
endmodule
